/* aib_pkg.sv */
package aib_pkg;
    localparam logic [7:0] SFR_AUX_POLL   = 8'h_A4;
    localparam logic [7:0] SFR_AUX_PEND   = 8'h_A5;
    localparam logic [7:0] SFR_AUX_MASK   = 8'h_A6;
    localparam logic [7:0] SFR_AUX_FLAGS  = 8'h_A7;
    localparam logic [7:0] SFR_IRQ_ENABLE = 8'h_A8;
    localparam logic [7:0] SFR_BRK_CTRL   = 8'h_A9;
    localparam logic [7:0] SFR_BRK_LOW    = 8'h_AA;
    localparam logic [7:0] SFR_BRK_HIGH   = 8'h_AB;
    localparam logic [7:0] SFR_SLOT_SEL   = 8'h_95;
    localparam logic [7:0] RST_BYTE       = 8'h_00;
    localparam int         BIT_GATE       = 7;
    localparam int         BIT_HIT        = 7;
    localparam int         BIT_CODE       = 1;
    localparam int         BIT_ARM        = 0;
    localparam int         BIT_RAWSEL     = 0;
    localparam int         BIT_ACC        = 6;
    localparam int         BIT_CONV       = 5;
    localparam int         BIT_DIGBRN     = 0;
    localparam int         NUM_AUX        = 8;
    localparam int         NUM_SLOTS      = 2;
endpackage : aib_pkg

/* aib_slot.sv */
`timescale 1ns/100ps
`default_nettype none
module aib_slot
    import aib_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_load,
    input  wire logic        i_arm,
    input  wire logic        i_code,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_clr,
    input  wire logic        i_dacc,
    input  wire logic [15:0] i_daddr,
    input  wire logic        i_pacc,
    input  wire logic [15:0] i_paddr,
    output logic             o_arm,
    output logic             o_code,
    output logic             o_hit
);
    logic        arm_r;
    logic        code_r;
    logic [15:0] addr_r;
    logic        hit_r;
    wire  [15:0] cmp_addr = code_r ? i_paddr : i_daddr;
    wire         cmp_acc  = code_r ? i_pacc : i_dacc;
    wire         match    = arm_r && cmp_acc && (cmp_addr == addr_r);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            arm_r  <= 1'b0;
            code_r <= 1'b0;
            addr_r <= 16'h_0000;
        end else if (i_load) begin
            arm_r  <= i_arm;
            code_r <= i_code;
            addr_r <= i_addr;
        end
    end
    // set beats a clear arriving in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) hit_r <= 1'b0;
        else if (match) hit_r <= 1'b1;
        else if (i_clr) hit_r <= 1'b0;
    end
    assign o_arm  = arm_r;
    assign o_code = code_r;
    assign o_hit  = hit_r;
endmodule : aib_slot
`default_nettype wire

/* aib_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module aib_ctrl
    import aib_pkg::*;
#(
    parameter int SLOTS = NUM_SLOTS
)(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_aux_src,
    input  wire logic        i_acc_low_rd,
    input  wire logic        i_conv_low_rd,
    input  wire logic        i_digbrn,
    input  wire logic [6:0]  i_irq_req,
    input  wire logic        i_dacc,
    input  wire logic [15:0] i_daddr,
    input  wire logic        i_pacc,
    input  wire logic [15:0] i_paddr,
    output logic [7:0]       o_sfr_rdata,
    output logic [6:0]       o_irq_gated,
    output logic             o_aux_irq,
    output logic [3:0]       o_aux_index
);
    logic [7:0] ien_r;
    logic [7:0] mask_r;
    logic       rawsel_r;
    logic [7:0] lo_r;
    logic [7:0] hi_r;
    logic [7:0] sel_r;
    logic [7:0] acc_sync_r;
    logic [7:0] src_sync_r;
    logic [1:0] bp_sync_r;
    logic       acc_lat_r;
    logic       conv_lat_r;
    logic [7:0] rdata_r;
    logic [6:0] gated_r;
    logic       aux_irq_r;
    logic [3:0] index_r;
    logic [SLOTS-1:0] hits;
    logic [SLOTS-1:0] arms;
    logic [SLOTS-1:0] codes;
    wire        wr_brk  = i_sfr_wr && (i_sfr_addr == SFR_BRK_CTRL);
    wire        any_hit = |hits;
    // raw sources: brownout ored with breakpoint on the top-priority line
    wire  [7:0] raw;
    assign raw[7]          = src_sync_r[7];
    assign raw[BIT_ACC]    = acc_lat_r;
    assign raw[BIT_CONV]   = conv_lat_r;
    assign raw[4:1]        = src_sync_r[4:1];
    assign raw[BIT_DIGBRN] = bp_sync_r[1] | any_hit;
    wire  [7:0] flags = raw & mask_r;
    wire  [7:0] poll_v  = rawsel_r ? raw : mask_r;
    wire  [7:0] maskv   = rawsel_r ? mask_r : raw;
    wire  [7:0] brkv = {any_hit, 5'h_00, codes[sel_r[0]], arms[sel_r[0]]};
    logic [3:0] idx;
    always_comb begin
        idx = 4'h_0;
        for (int k = NUM_AUX - 1; k >= 0; k--) begin
            if (flags[k]) idx = 4'(k + 1);
        end
    end
    logic [7:0] rd_mux;
    always_comb begin
        case (i_sfr_addr)
            SFR_AUX_POLL:   rd_mux = poll_v;
            SFR_AUX_PEND:   rd_mux = {4'h_0, idx};
            SFR_AUX_MASK:   rd_mux = maskv;
            SFR_AUX_FLAGS:  rd_mux = flags;
            SFR_IRQ_ENABLE: rd_mux = ien_r;
            SFR_BRK_CTRL:   rd_mux = brkv;
            SFR_BRK_LOW:    rd_mux = lo_r;
            SFR_BRK_HIGH:   rd_mux = hi_r;
            SFR_SLOT_SEL:   rd_mux = sel_r;
            default:        rd_mux = RST_BYTE;
        endcase
    end
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            aib_slot u_slot (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_load  (wr_brk && (sel_r[0] == 1'(g))),
                .i_arm   (i_sfr_wdata[BIT_ARM]),
                .i_code  (i_sfr_wdata[BIT_CODE]),
                .i_addr  ({hi_r, lo_r}),
                .i_clr   (wr_brk && i_sfr_wdata[BIT_HIT] && (sel_r[0] == 1'(g))),
                .i_dacc  (i_dacc),
                .i_daddr (i_daddr),
                .i_pacc  (i_pacc),
                .i_paddr (i_paddr),
                .o_arm   (arms[g]),
                .o_code  (codes[g]),
                .o_hit   (hits[g])
            );
        end
    endgenerate
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ien_r    <= RST_BYTE;
            mask_r   <= RST_BYTE;
            rawsel_r <= 1'b0;
            lo_r     <= RST_BYTE;
            hi_r     <= RST_BYTE;
            sel_r    <= RST_BYTE;
        end else if (i_sfr_wr) begin
            case (i_sfr_addr)
                SFR_IRQ_ENABLE: ien_r    <= i_sfr_wdata;
                SFR_AUX_MASK:   mask_r   <= i_sfr_wdata;
                SFR_AUX_POLL:   rawsel_r <= i_sfr_wdata[BIT_RAWSEL];
                SFR_BRK_LOW:    lo_r     <= i_sfr_wdata;
                SFR_BRK_HIGH:   hi_r     <= i_sfr_wdata;
                SFR_SLOT_SEL:   sel_r    <= i_sfr_wdata;
                default:        ;
            endcase
        end
    end
    // pins come from other logic blocks of unknown timing, hence two stages
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_sync_r <= RST_BYTE;
            src_sync_r <= RST_BYTE;
            bp_sync_r  <= 2'b00;
        end else begin
            acc_sync_r <= i_aux_src;
            src_sync_r <= acc_sync_r;
            bp_sync_r  <= {bp_sync_r[0], i_digbrn};
        end
    end
    // accumulator and converter flags latch, cleared by the low result byte read
    wire acc_rise  = src_sync_r[BIT_ACC];
    wire conv_rise = src_sync_r[BIT_CONV];
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_lat_r  <= 1'b0;
            conv_lat_r <= 1'b0;
        end else begin
            acc_lat_r  <= acc_rise | (acc_lat_r & ~i_acc_low_rd);
            conv_lat_r <= conv_rise | (conv_lat_r & ~i_conv_low_rd);
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r   <= RST_BYTE;
            gated_r   <= 7'h_00;
            aux_irq_r <= 1'b0;
            index_r   <= 4'h_0;
        end else begin
            rdata_r   <= i_sfr_rd ? rd_mux : RST_BYTE;
            gated_r   <= ien_r[BIT_GATE] ? (i_irq_req & ien_r[6:0]) : 7'h_00;
            aux_irq_r <= |flags;
            index_r   <= idx;
        end
    end
    assign o_sfr_rdata = rdata_r;
    assign o_irq_gated = gated_r;
    assign o_aux_irq   = aux_irq_r;
    assign o_aux_index = index_r;

    property p_gate;
        @(posedge i_clk) disable iff (i_rst)
        !ien_r[BIT_GATE] |=> (o_irq_gated == 7'h_00);
    endproperty
    a_gate: assert property (p_gate) else $error("gate off but irq passed");
    property p_mask;
        @(posedge i_clk) disable iff (i_rst)
        !mask_r[BIT_DIGBRN] |-> !flags[BIT_DIGBRN];
    endproperty
    a_mask: assert property (p_mask) else $error("masked source shown");
    property p_hitflag;
        @(posedge i_clk) disable iff (i_rst)
        (any_hit && i_sfr_rd && (i_sfr_addr == SFR_BRK_CTRL)) |=> o_sfr_rdata[BIT_HIT];
    endproperty
    a_hitflag: assert property (p_hitflag) else $error("hit not reported");
    property p_disarmed;
        @(posedge i_clk) disable iff (i_rst)
        (!arms[0] && !hits[0]) |=> !hits[0];
    endproperty
    a_disarmed: assert property (p_disarmed) else $error("disarmed slot hit");
    property p_pend;
        @(posedge i_clk) disable iff (i_rst)
        flags[0] |=> (o_aux_index == 4'h_1);
    endproperty
    a_pend: assert property (p_pend) else $error("wrong pending index");
    property p_lowbit;
        @(posedge i_clk) disable iff (i_rst)
        (mask_r[0] && any_hit) |=> (o_aux_irq && (o_aux_index == 4'h_1));
    endproperty
    a_lowbit: assert property (p_lowbit) else $error("break not in status");
    sequence s_load0;
        wr_brk && sel_r[0] == 1'b0 && i_sfr_wdata[BIT_ARM];
    endsequence
    property p_load;
        @(posedge i_clk) disable iff (i_rst)
        s_load0 |=> arms[0];
    endproperty
    a_load: assert property (p_load) else $error("slot not armed by write");
    property p_accclr;
        @(posedge i_clk) disable iff (i_rst)
        (i_acc_low_rd && !acc_rise) |=> !acc_lat_r;
    endproperty
    a_accclr: assert property (p_accclr) else $error("flag not cleared by read");
endmodule : aib_ctrl
`default_nettype wire

/* aib_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module aib_core_model (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic        i_prog,
    input  wire logic [15:0] i_addr,
    output logic             o_dacc,
    output logic [15:0]      o_daddr,
    output logic             o_pacc,
    output logic [15:0]      o_paddr
);
    // idle bus shows the inverse so a stale address cannot match
    always @(posedge i_clk) begin
        o_dacc  <= i_go & ~i_prog;
        o_pacc  <= i_go & i_prog;
        o_daddr <= (i_go & ~i_prog) ? i_addr : ~i_addr;
        o_paddr <= (i_go & i_prog) ? i_addr : ~i_addr;
    end
endmodule : aib_core_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
    import aib_pkg::*;
;
    logic        i_clk, i_rst, wr, rd, go, prog, dacc, pacc;
    logic        acc_rd, conv_rd, digbrn, aux_irq;
    logic [3:0]  aux_idx;
    logic [7:0]  addr, wdata, rdata, src;
    logic [6:0]  req, gated;
    logic [15:0] baddr, daddr, paddr;
    int          fails, checks;
    aib_core_model core_u (.i_clk(i_clk), .i_go(go), .i_prog(prog), .i_addr(baddr),
        .o_dacc(dacc), .o_daddr(daddr), .o_pacc(pacc), .o_paddr(paddr));
    aib_ctrl dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .i_aux_src(src), .i_acc_low_rd(acc_rd),
        .i_conv_low_rd(conv_rd), .i_digbrn(digbrn), .i_irq_req(req), .i_dacc(dacc),
        .i_daddr(daddr), .i_pacc(pacc), .i_paddr(paddr), .o_sfr_rdata(rdata),
        .o_irq_gated(gated), .o_aux_irq(aux_irq), .o_aux_index(aux_idx));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) #1;
        addr = a; wdata = d; wr = 1'b1;
        @(posedge i_clk) #1;
        wr = 1'b0;
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk) #1;
        addr = a; rd = 1'b1;
        @(posedge i_clk) #1;
        d = rdata; rd = 1'b0;
    endtask : sfr_rd
    task automatic access(input logic p, input logic [15:0] a);
        @(posedge i_clk) #1;
        go = 1'b1; prog = p; baddr = a;
        @(posedge i_clk) #1;
        go = 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : access
    task automatic t_reset;
        logic [7:0] d;
        sfr_rd(SFR_AUX_FLAGS, d);  chk("aux_irq_flags", d, RST_BYTE);
        sfr_rd(SFR_IRQ_ENABLE, d); chk("irq_enable", d, RST_BYTE);
        sfr_rd(SFR_BRK_CTRL, d);   chk("break_control", d, RST_BYTE);
        sfr_rd(SFR_BRK_LOW, d);    chk("break_addr_low", d, RST_BYTE);
        sfr_rd(8'h_B0, d);         chk("unmapped", d, 8'h_00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_break;
        logic [7:0] d;
        sfr_wr(SFR_SLOT_SEL, 8'h_00);
        sfr_wr(SFR_BRK_HIGH, 8'h_12);
        sfr_wr(SFR_BRK_LOW, 8'h_34);
        sfr_wr(SFR_BRK_CTRL, 8'h_01);
        sfr_rd(SFR_BRK_LOW, d);  chk("break_addr_low", d, 8'h_34);
        access(1'b1, 16'h_1234);
        access(1'b0, 16'h_1235);
        sfr_rd(SFR_BRK_CTRL, d); chk("no hit", d, 8'h_01);
        access(1'b0, 16'h_1234);
        sfr_rd(SFR_BRK_CTRL, d); chk("data hit", d, 8'h_81);
        sfr_rd(SFR_AUX_FLAGS, d); chk("aux bit0 masked", d, 8'h_00);
        sfr_wr(SFR_AUX_MASK, 8'h_01);
        repeat (2) @(posedge i_clk);
        sfr_rd(SFR_AUX_FLAGS, d); chk("aux bit0", d, 8'h_01);
        sfr_wr(SFR_BRK_CTRL, 8'h_01);
        sfr_rd(SFR_BRK_CTRL, d); chk("zero keeps hit", d, 8'h_81);
        sfr_wr(SFR_BRK_CTRL, 8'h_80);
        sfr_rd(SFR_BRK_CTRL, d); chk("clear hit", d, 8'h_00);
        access(1'b0, 16'h_1234);
        sfr_rd(SFR_BRK_CTRL, d); chk("disarmed", d, 8'h_00);
        sfr_wr(SFR_SLOT_SEL, 8'h_01);
        sfr_wr(SFR_BRK_HIGH, 8'h_AB);
        sfr_wr(SFR_BRK_LOW, 8'h_CD);
        sfr_wr(SFR_BRK_CTRL, 8'h_03);
        access(1'b1, 16'h_ABCD);
        sfr_wr(SFR_SLOT_SEL, 8'h_00);
        sfr_rd(SFR_BRK_CTRL, d); chk("other slot hit", d, 8'h_80);
        $display("test break done");
    endtask : t_break
    task automatic t_gate;
        logic [7:0] d;
        req = 7'h_7F;
        sfr_wr(SFR_IRQ_ENABLE, 8'h_7F);
        repeat (2) @(posedge i_clk);
        #1;
        chk("gated off", {1'b0, gated}, 8'h_00);
        sfr_wr(SFR_IRQ_ENABLE, 8'h_A5);
        repeat (2) @(posedge i_clk);
        #1;
        chk("gated on", {1'b0, gated}, 8'h_25);
        sfr_rd(SFR_IRQ_ENABLE, d); chk("irq_enable", d, 8'h_A5);
        $display("test gate done");
    endtask : t_gate
    task automatic t_aux;
        logic [7:0] d;
        sfr_wr(SFR_AUX_MASK, 8'h_FE);
        src = 8'h_12;
        repeat (5) @(posedge i_clk);
        sfr_rd(SFR_AUX_FLAGS, d); chk("aux flags", d, 8'h_12);
        sfr_wr(SFR_AUX_MASK, 8'h_10);
        repeat (2) @(posedge i_clk);
        sfr_rd(SFR_AUX_FLAGS, d); chk("aux masked", d, 8'h_10);
        $display("test aux done");
    endtask : t_aux
    task automatic t_pend;
        logic [7:0] d;
        sfr_wr(SFR_SLOT_SEL, 8'h_01);
        sfr_wr(SFR_BRK_CTRL, 8'h_80);
        sfr_wr(SFR_AUX_MASK, 8'h_11);
        sfr_rd(SFR_AUX_PEND, d); chk("pending khz", d, 8'h_05);
        chk("aux index", {4'h_0, aux_idx}, 8'h_05);
        chk("aux irq", {7'h_00, aux_irq}, 8'h_01);
        digbrn = 1'b1;
        repeat (4) @(posedge i_clk);
        sfr_rd(SFR_AUX_PEND, d); chk("pending brownout", d, 8'h_01);
        chk("aux index top", {4'h_0, aux_idx}, 8'h_01);
        sfr_wr(SFR_AUX_POLL, 8'h_00);
        sfr_rd(SFR_AUX_POLL, d); chk("poll shows mask", d, 8'h_11);
        sfr_rd(SFR_AUX_MASK, d); chk("mask shows raw", d, 8'h_13);
        sfr_wr(SFR_AUX_POLL, 8'h_01);
        sfr_rd(SFR_AUX_POLL, d); chk("poll shows raw", d, 8'h_13);
        sfr_rd(SFR_AUX_MASK, d); chk("mask shows mask", d, 8'h_11);
        digbrn = 1'b0;
        sfr_wr(SFR_AUX_MASK, 8'h_00);
        sfr_rd(SFR_AUX_PEND, d); chk("none pending", d, 8'h_00);
        chk("aux irq off", {7'h_00, aux_irq}, 8'h_00);
        $display("test pend done");
    endtask : t_pend
    task automatic t_latch;
        logic [7:0] d;
        sfr_wr(SFR_AUX_MASK, 8'h_60);
        src = 8'h_60;
        repeat (4) @(posedge i_clk);
        #1 src = 8'h_00;
        repeat (4) @(posedge i_clk);
        sfr_rd(SFR_AUX_FLAGS, d); chk("results latched", d, 8'h_60);
        @(posedge i_clk) #1 acc_rd = 1'b1;
        @(posedge i_clk) #1 acc_rd = 1'b0;
        sfr_rd(SFR_AUX_FLAGS, d); chk("acc read clears", d, 8'h_20);
        @(posedge i_clk) #1 conv_rd = 1'b1;
        @(posedge i_clk) #1 conv_rd = 1'b0;
        sfr_rd(SFR_AUX_FLAGS, d); chk("conv read clears", d, 8'h_00);
        $display("test latch done");
    endtask : t_latch
    task automatic t_rerst;
        logic [7:0] d;
        @(posedge i_clk) #1 i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1 i_rst = 1'b0;
        sfr_rd(SFR_IRQ_ENABLE, d); chk("irq_enable after reset", d, RST_BYTE);
        chk("gated after reset", {1'b0, gated}, 8'h_00);
        $display("test rerst done");
    endtask : t_rerst
    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    initial begin
        fails = 0; checks = 0; i_rst = 1'b1; wr = 1'b0; rd = 1'b0; go = 1'b0; prog = 1'b0;
        addr = 8'h_00; wdata = 8'h_00; src = 8'h_00; req = 7'h_00; baddr = 16'h_0000;
        acc_rd = 1'b0; conv_rd = 1'b0; digbrn = 1'b0;
        repeat (3) @(posedge i_clk);
        #1 i_rst = 1'b0;
        t_reset;
        t_break;
        t_gate;
        t_aux;
        t_pend;
        t_latch;
        t_rerst;
        wrap_up;
    end
    initial begin
        #200000;
        fails++;
        wrap_up;
    end
endmodule : testbench
`default_nettype wire
